// *** verilog/twowire_master.sv ***
// Master end: runs register write and read transactions on the link.
// Assumes a slave at the address picked by addr_sel; the clock wire is
// made here by dividing clk, four quarters per bit.
`timescale 1ns/1ps
module twowire_master (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic [2:0] addr_sel,
  input  wire logic       cmd_valid,
  output logic            cmd_ready,
  input  wire logic       cmd_read,
  input  wire logic [7:0] cmd_sub,
  input  wire logic [3:0] cmd_len,
  input  wire logic       wdata_valid,
  output logic            wdata_ready,
  input  wire logic [7:0] wdata,
  output logic            rdata_valid,
  output logic [7:0]      rdata,
  output logic            done,
  output logic            nacked,
  twowire_if.master       bus
);
  localparam logic [7:0] QLAST = 8'(twowire_pkg::QUARTER_CYC - 1);

  typedef enum logic [4:0] {
    M_IDLE  = 5'h01,
    M_START = 5'h02,
    M_BIT   = 5'h04,
    M_STOP  = 5'h08,
    M_LOAD  = 5'h10
  } mst_e;

  typedef enum logic [4:0] {
    K_AW  = 5'h01,
    K_SUB = 5'h02,
    K_DW  = 5'h04,
    K_AR  = 5'h08,
    K_DR  = 5'h10
  } kind_e;

  typedef struct packed {
    logic [2:0] sda_sy;
    logic       sda_q;
    mst_e       st;
    kind_e      kind;
    logic [7:0] qc;
    logic [1:0] q;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [3:0] rem;
    logic       rd;
    logic [7:0] sub;
    logic       err;
    logic       scl_oe;
    logic       sda_oe;
    logic       crdy;
    logic       wrdy;
    logic       rv;
    logic [7:0] rdat;
    logic       dn;
    logic       nk;
  } mst_s;

  mst_s       r;
  mst_s       n;
  logic       tick;
  logic       bdone;
  logic [6:0] addr7;

  always_comb begin
    n = r;
    n.rv = 1'b0;
    n.dn = 1'b0;
    addr7 = twowire_pkg::BASE_ADDR7 + {4'h0, addr_sel};
    n.sda_sy = {r.sda_sy[1:0], bus.sda};
    if (r.sda_sy[1] == r.sda_sy[2]) begin
      n.sda_q = r.sda_sy[2];
    end
    tick = r.qc == QLAST;
    bdone = 1'b0;
    if (r.st == M_START || r.st == M_BIT || r.st == M_STOP) begin
      n.qc = tick ? 8'h00 : r.qc + 8'h01;
      if (tick) begin
        n.q = r.q + 2'h1;
      end
    end
    unique case (r.st)
      M_IDLE: begin
        n.crdy = 1'b1;
        if (r.crdy && cmd_valid) begin
          n.crdy = 1'b0;
          n.rd = cmd_read;
          n.sub = cmd_sub;
          n.rem = (cmd_read && cmd_len == 4'h0) ? 4'h1 : cmd_len;
          n.err = 1'b0;
          n.kind = K_AW;
          n.sh = {addr7, twowire_pkg::DIR_WRITE};
          n.st = M_START;
        end
      end
      M_START: begin
        if (tick) begin
          unique case (r.q)
            2'h0: n.sda_oe = 1'b0;
            2'h1: n.scl_oe = 1'b0;
            2'h2: n.sda_oe = 1'b1;
            2'h3: begin
              n.scl_oe = 1'b1;
              n.st = M_BIT;
              n.cnt = '0;
            end
          endcase
        end
      end
      M_BIT: begin
        if (tick) begin
          unique case (r.q)
            2'h0: begin
              if (r.kind == K_DR) begin
                n.sda_oe = r.cnt == twowire_pkg::BYTE_BITS && r.rem != 4'h1;
              end else begin
                n.sda_oe = r.cnt != twowire_pkg::BYTE_BITS && !r.sh[7];
              end
            end
            2'h1: n.scl_oe = 1'b0;
            2'h2: begin
              if (r.cnt != twowire_pkg::BYTE_BITS) begin
                if (r.kind == K_DR) begin
                  n.sh = {r.sh[6:0], r.sda_q};
                end
              end else if (r.kind != K_DR) begin
                n.err = r.sda_q;
              end
            end
            2'h3: begin
              n.scl_oe = 1'b1;
              n.cnt = r.cnt + 4'h1;
              if (r.cnt == twowire_pkg::BYTE_BITS) begin
                bdone = 1'b1;
              end else if (r.kind != K_DR) begin
                n.sh = {r.sh[6:0], 1'b0};
              end
            end
          endcase
        end
        if (bdone) begin
          n.cnt = '0;
          n.sda_oe = 1'b0;
          if (r.err) begin
            n.st = M_STOP;
          end else begin
            unique case (r.kind)
              K_AW: begin
                n.kind = K_SUB;
                n.sh = r.sub;
              end
              K_SUB: begin
                if (r.rd) begin
                  n.kind = K_AR;
                  n.sh = {addr7, twowire_pkg::DIR_READ};
                  n.st = M_START;
                end else begin
                  n.kind = K_DW;
                  n.st = r.rem == 4'h0 ? M_STOP : M_LOAD;
                end
              end
              K_DW: begin
                n.rem = r.rem - 4'h1;
                n.st = n.rem == 4'h0 ? M_STOP : M_LOAD;
              end
              K_AR: begin
                n.kind = K_DR;
              end
              K_DR: begin
                n.rv = 1'b1;
                n.rdat = r.sh;
                n.rem = r.rem - 4'h1;
                if (n.rem == 4'h0) begin
                  n.st = M_STOP;
                end
              end
              default: n.st = M_STOP;
            endcase
          end
        end
      end
      M_STOP: begin
        if (tick) begin
          unique case (r.q)
            2'h0: n.sda_oe = 1'b1;
            2'h1: n.scl_oe = 1'b0;
            2'h2: n.sda_oe = 1'b0;
            2'h3: begin
              n.st = M_IDLE;
              n.dn = 1'b1;
              n.nk = r.err;
            end
          endcase
        end
      end
      M_LOAD: begin
        n.wrdy = 1'b1;
        if (r.wrdy && wdata_valid) begin
          n.wrdy = 1'b0;
          n.sh = wdata;
          n.st = M_BIT;
        end
      end
      default: n.st = M_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      r <= '0;
      r.sda_sy <= 3'h7;
      r.sda_q <= 1'b1;
      r.st <= M_IDLE;
      r.kind <= K_AW;
    end else begin
      r <= n;
    end
  end

  // Both wires are open-drain: enable means pulling the wire low.
  assign bus.scl_o_m  = 1'b0;
  assign bus.scl_oe_m = r.scl_oe;
  assign bus.sda_o_m  = 1'b0;
  assign bus.sda_oe_m = r.sda_oe;
  assign cmd_ready    = r.crdy;
  assign wdata_ready  = r.wrdy;
  assign rdata_valid  = r.rv;
  assign rdata        = r.rdat;
  assign done         = r.dn;
  assign nacked       = r.nk;
endmodule

// *** verilog/twowire_pkg.sv ***
// Shared constants for the two-wire register access link.
// Assumes a 25 MHz system clock on both ends.
package twowire_pkg;
  localparam int         CLK_NS      = 40;
  localparam int         QUARTER_NS  = 400;
  localparam int         QUARTER_CYC = (QUARTER_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [6:0] BASE_ADDR7  = 7'h38;
  localparam logic [3:0] BYTE_BITS   = 4'h8;
  localparam logic [3:0] FRAME_BITS  = 4'h9;
  localparam logic       DIR_READ    = 1'b1;
  localparam logic       DIR_WRITE   = 1'b0;
  localparam int         FIFO_W      = 16;
  localparam int         FIFO_D      = 16;
endpackage

// *** verilog/twowire_if.sv ***
// Open-drain clock and data wires shared by master and slave ends.
// Assumes pull-ups: a wire is low only while some end drives it low.
`timescale 1ns/1ps
interface twowire_if;
  logic scl_o_m;
  logic scl_oe_m;
  logic sda_o_m;
  logic sda_oe_m;
  logic sda_o_s;
  logic sda_oe_s;
  logic scl;
  logic sda;

  assign scl = !(scl_oe_m && !scl_o_m);
  assign sda = !((sda_oe_m && !sda_o_m) || (sda_oe_s && !sda_o_s));

  modport master (output scl_o_m, output scl_oe_m, output sda_o_m, output sda_oe_m, input scl, input sda);
  modport slave  (output sda_o_s, output sda_oe_s, input scl, input sda);
endinterface

// *** verilog/twowire_fifo.sv ***
// Small flip-flop FIFO with valid and ready on both sides.
// Assumes both sides run on clk; in_ready and out_valid are registered.
`timescale 1ns/1ps
module twowire_fifo #(
  parameter int W = 16,
  parameter int D = 16
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  localparam int CW = $clog2(D + 1);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [CW-1:0]       cnt;
    logic                ov;
    logic                ir;
  } fifo_s;

  fifo_s r;
  fifo_s n;
  logic  push;
  logic  pop;

  always_comb begin
    n = r;
    push = in_valid && r.ir;
    pop = r.ov && out_ready;
    for (int i = 0; i < D; i++) begin
      if (push && r.wp == AW'(i)) begin
        n.mem[i] = in_data;
      end
    end
    if (push) begin
      n.wp = r.wp + AW'(1);
    end
    if (pop) begin
      n.rp = r.rp + AW'(1);
    end
    n.cnt = r.cnt + CW'(push) - CW'(pop);
    n.ov = n.cnt != '0;
    n.ir = n.cnt != CW'(D);
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      r <= '0;
      r.ir <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign in_ready  = r.ir;
  assign out_valid = r.ov;
  assign out_data  = r.mem[r.rp];
endmodule

// *** verilog/twowire_slave.sv ***
// Slave end: decodes the two-wire link and gives access to a register space.
// Assumes the master end drives the clock wire; register reads are served
// combinationally on rd_data for the address on rd_addr; writes leave
// through a FIFO as address and data pairs.
`timescale 1ns/1ps
module twowire_slave (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic [2:0] addr_sel,
  output logic [7:0]      rd_addr,
  input  wire logic [7:0] rd_data,
  output logic            wr_valid,
  input  wire logic       wr_ready,
  output logic [7:0]      wr_addr,
  output logic [7:0]      wr_data,
  output logic            addressed,
  twowire_if.slave        bus
);
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_ADDR = 5'h02,
    ST_SUB  = 5'h04,
    ST_WR   = 5'h08,
    ST_RD   = 5'h10
  } st_e;

  typedef struct packed {
    logic [2:0]  scl_sy;
    logic [2:0]  sda_sy;
    logic        scl_q;
    logic        sda_q;
    st_e         st;
    logic [3:0]  cnt;
    logic [7:0]  sh;
    logic [7:0]  ptr;
    logic        sda_oe;
    logic        push;
    logic [15:0] pdata;
    logic        adr;
  } slv_s;

  slv_s        r;
  slv_s        n;
  logic        rise;
  logic        fall;
  logic        start;
  logic        stop;
  logic        fifo_rdy;
  logic [6:0]  own_addr;
  logic [15:0] fifo_out;

  always_comb begin
    n = r;
    n.push = 1'b0;
    own_addr = twowire_pkg::BASE_ADDR7 + {4'h0, addr_sel};
    n.scl_sy = {r.scl_sy[1:0], bus.scl};
    n.sda_sy = {r.sda_sy[1:0], bus.sda};
    if (r.scl_sy[1] == r.scl_sy[2]) begin
      n.scl_q = r.scl_sy[2];
    end
    if (r.sda_sy[1] == r.sda_sy[2]) begin
      n.sda_q = r.sda_sy[2];
    end
    rise = !r.scl_q && n.scl_q;
    fall = r.scl_q && !n.scl_q;
    start = r.scl_q && n.scl_q && r.sda_q && !n.sda_q;
    stop = r.scl_q && n.scl_q && !r.sda_q && n.sda_q;
    if (start) begin
      n.st = ST_ADDR;
      n.cnt = '0;
      n.sda_oe = 1'b0;
    end else if (stop) begin
      n.st = ST_IDLE;
      n.sda_oe = 1'b0;
    end else if (r.st != ST_IDLE) begin
      if (rise) begin
        n.cnt = r.cnt + 4'h1;
        if (r.cnt < twowire_pkg::BYTE_BITS) begin
          if (r.st != ST_RD) begin
            n.sh = {r.sh[6:0], n.sda_q};
          end
        end else if (r.st == ST_RD) begin
          n.ptr = r.ptr + 8'h01;
          if (n.sda_q) begin
            n.st = ST_IDLE;
            n.sda_oe = 1'b0;
          end
        end
      end else if (fall) begin
        if (r.cnt == twowire_pkg::BYTE_BITS) begin
          unique case (r.st)
            ST_ADDR: begin
              if (r.sh[7:1] == own_addr) begin
                n.sda_oe = 1'b1;
              end else begin
                n.st = ST_IDLE;
              end
            end
            ST_SUB: begin
              n.sda_oe = 1'b1;
              n.ptr = r.sh;
            end
            ST_WR: begin
              // A full FIFO refuses the byte with a nack rather than losing it.
              if (fifo_rdy) begin
                n.sda_oe = 1'b1;
                n.push = 1'b1;
                n.pdata = {r.ptr, r.sh};
                n.ptr = r.ptr + 8'h01;
              end else begin
                n.st = ST_IDLE;
              end
            end
            ST_RD: begin
              n.sda_oe = 1'b0;
            end
            default: begin
              n.st = ST_IDLE;
            end
          endcase
        end else if (r.cnt == twowire_pkg::FRAME_BITS) begin
          n.cnt = '0;
          n.sda_oe = 1'b0;
          unique case (r.st)
            ST_ADDR: begin
              n.st = (r.sh[0] == twowire_pkg::DIR_READ) ? ST_RD : ST_SUB;
            end
            ST_SUB: begin
              n.st = ST_WR;
            end
            ST_WR: begin
              n.st = ST_WR;
            end
            ST_RD: begin
              n.st = ST_RD;
            end
            default: begin
              n.st = ST_IDLE;
            end
          endcase
          if (n.st == ST_RD) begin
            n.sh = rd_data;
            n.sda_oe = !rd_data[7];
          end
        end else if (r.st == ST_RD) begin
          n.sh = {r.sh[6:0], 1'b0};
          n.sda_oe = !r.sh[6];
        end
      end
    end
    n.adr = n.st != ST_IDLE && n.st != ST_ADDR;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      r <= '0;
      r.scl_sy <= 3'h7;
      r.sda_sy <= 3'h7;
      r.scl_q <= 1'b1;
      r.sda_q <= 1'b1;
      r.st <= ST_IDLE;
    end else begin
      r <= n;
    end
  end

  twowire_fifo #(
    .W (twowire_pkg::FIFO_W),
    .D (twowire_pkg::FIFO_D)
  ) u_fifo (
    .clk       (clk),
    .nrst      (nrst),
    .in_valid  (r.push),
    .in_ready  (fifo_rdy),
    .in_data   (r.pdata),
    .out_valid (wr_valid),
    .out_ready (wr_ready),
    .out_data  (fifo_out)
  );

  // The line is open-drain, so only a low is ever driven.
  assign bus.sda_o_s  = 1'b0;
  assign bus.sda_oe_s = r.sda_oe;
  assign rd_addr      = r.ptr;
  assign wr_addr      = fifo_out[15:8];
  assign wr_data      = fifo_out[7:0];
  assign addressed    = r.adr;
endmodule

// *** test/twowire_assertions.sv ***
// Checks on the link joining the master and slave ends.
// Assumes it sees the resolved wires, both data enables and the slave select.
`timescale 1ns/1ps
module twowire_assertions (
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic [2:0] addr_sel,
  input wire logic       scl,
  input wire logic       sda,
  input wire logic       sda_oe_m,
  input wire logic       sda_oe_s
);
  logic       scl_q, sda_q, inframe, dir, match, mute, rise, start_ev, stop_ev, nine;
  logic [3:0] bitcnt;
  logic [1:0] byteidx;
  logic [7:0] sh;
  logic [6:0] own;
  assign own      = twowire_pkg::BASE_ADDR7 + {4'h0, addr_sel};
  assign rise     = scl && !scl_q;
  assign start_ev = scl && scl_q && sda_q && !sda;
  assign stop_ev  = scl && scl_q && !sda_q && sda;
  assign nine     = inframe && rise && bitcnt == 4'h8;
  // The rise before a restart or stop is counted too, so a frame closes at a count of one.
  always_ff @(posedge clk) begin
    scl_q <= scl;
    sda_q <= sda;
    if (!nrst) begin
      inframe <= 1'b0;
      mute    <= 1'b0;
    end else if (start_ev) begin
      inframe <= 1'b1;
      bitcnt  <= 4'h0;
      byteidx <= 2'h0;
      mute    <= 1'b0;
    end else if (stop_ev) begin
      inframe <= 1'b0;
    end else if (rise && inframe && bitcnt != 4'h8) begin
      sh     <= {sh[6:0], sda};
      bitcnt <= bitcnt + 4'h1;
    end else if (nine) begin
      bitcnt  <= 4'h0;
      byteidx <= byteidx == 2'h2 ? byteidx : byteidx + 2'h1;
      dir     <= byteidx == 2'h0 ? sh[0] : dir;
      match   <= byteidx == 2'h0 ? sh[7:1] == own : match;
      mute    <= mute || (byteidx == 2'h0 ? sh[7:1] != own : dir && sda);
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  chk_addr_ack: assert property (nine && byteidx == 2'h0 && sh[7:1] == own |-> !sda)
    else $error("own address not acknowledged");
  chk_addr_miss: assert property (nine && byteidx == 2'h0 && sh[7:1] != own |-> sda)
    else $error("foreign address acknowledged");
  chk_sub_ack: assert property (nine && byteidx == 2'h1 && !dir && match |-> !sda)
    else $error("sub-address not acknowledged");
  chk_master_release: assert property (nine && (byteidx == 2'h0 || !dir) |-> !sda_oe_m)
    else $error("master drives data in acknowledge");
  chk_slave_release: assert property (nine && byteidx != 2'h0 && dir |-> !sda_oe_s)
    else $error("slave drives data in acknowledge");
  chk_slave_quiet: assert property (mute |-> !sda_oe_s)
    else $error("slave drives data after refusal");
  chk_slave_steady: assert property (scl && scl_q |-> $stable(sda_oe_s))
    else $error("slave data moved while clock high");
  chk_frame_bits: assert property (inframe && (start_ev || stop_ev) |-> bitcnt == 4'h1)
    else $error("frame ended off a byte boundary");
  chk_idle_clock: assert property (!inframe |-> scl)
    else $error("clock moved outside a frame");
  cover property (nine && byteidx == 2'h0 && sh[7:1] == own && sh[0]);
  cover property (nine && byteidx == 2'h2 && !dir && !sda);
  cover property (nine && byteidx != 2'h0 && dir && sda);
  cover property (inframe && start_ev);
endmodule

// *** test/tb_serial_register_access_slave.sv ***
// Bench joining the master and slave ends over one link; models the register space.
// Assumes package, interface, design modules and checker are compiled first.
`timescale 1ns/1ps
module tb_serial_register_access_slave;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        cmd_valid, cmd_ready, cmd_read, wdata_valid, wdata_ready, rdata_valid, done, nacked;
  logic        wr_valid, wr_ready, hold, pv, scl_p, sda_p, addressed;
  logic        pend = 1'b0;
  logic [2:0]  sel_m, sel_s;
  logic [3:0]  cmd_len;
  logic [7:0]  cmd_sub, wdata, rdata, rd_addr, rd_data, wr_addr, wr_data, sh;
  logic [7:0]  mem [256];
  logic [15:0] wq [$];
  logic [7:0]  rq [$];
  logic        nq [$];
  int          seed = 32'h47b5dbf3;
  int          errors = 0;
  int          checks_done = 0;
  int          bc;
  int          bits = 8;
  twowire_if link ();
  twowire_master i_twowire_master (.clk, .nrst, .addr_sel(sel_m), .cmd_valid, .cmd_ready, .cmd_read, .cmd_sub,
    .cmd_len, .wdata_valid, .wdata_ready, .wdata, .rdata_valid, .rdata, .done, .nacked, .bus(link));
  twowire_slave i_twowire_slave (.clk, .nrst, .addr_sel(sel_s), .rd_addr, .rd_data, .wr_valid, .wr_ready,
    .wr_addr, .wr_data, .addressed, .bus(link));
  twowire_assertions i_twowire_assertions (.clk, .nrst, .addr_sel(sel_s), .scl(link.scl), .sda(link.sda),
    .sda_oe_m(link.sda_oe_m), .sda_oe_s(link.sda_oe_s));
  // Writes leave only through the FIFO, so the modelled registers stay fixed and reads stay predictable.
  assign rd_data = mem[rd_addr];
  always #20 clk = ~clk;
  always @(posedge clk) wr_ready <= !hold && ($random(seed) & 1);
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done;
    if (errors == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic drain;
    repeat (4) @(posedge clk);
    for (bc = 0; wq.size() != 0 && bc < 4000; bc++) @(posedge clk);
  endtask
  task automatic xfer(input logic rd, input logic [3:0] len, input int ok, input logic nk);
    logic [7:0] sub;
    logic [7:0] dq [$];
    int         i;
    sub = $random(seed);
    i = 0;
    for (int k = 0; k < 16; k++) begin
      dq.push_back($random(seed));
      if (k < ok && rd) rq.push_back(mem[sub + k[7:0]]);
      if (k < ok && !rd) wq.push_back({sub + k[7:0], dq[k]});
    end
    nq.push_back(nk);
    @(posedge clk);
    {cmd_valid, cmd_read, cmd_sub, cmd_len} <= {1'b1, rd, sub, len};
    wdata_valid <= !rd && len != 4'h0;
    wdata <= dq[0];
    do @(posedge clk); while (!cmd_ready);
    cmd_valid <= 1'b0;
    for (bc = 0; !done && bc < 9000; bc++) begin
      @(posedge clk);
      if (wdata_valid && wdata_ready) begin
        i++;
        wdata <= dq[i];
        if (i == len) wdata_valid <= 1'b0;
      end
    end
    if (bc == 9000) errors++;
    wdata_valid <= 1'b0;
  endtask
  always @(negedge clk) begin
    if (wr_valid && wr_ready) chk({wr_addr, wr_data}, wq.size() ? wq.pop_front() : 16'hxxxx, "pair");
    if (nrst && rdata_valid) begin
      chk(rdata, rq.size() ? rq.pop_front() : 8'hxx, "read byte");
      chk(addressed, rq.size() != 0, "addressed in read");
    end
    if (pend) chk(nacked, pv, "nacked");
    if (done) chk(addressed, 1'b0, "addressed after stop");
    pend = done;
    if (done) pv = nq.pop_front();
    if (link.scl && scl_p && sda_p && !link.sda) begin
      bits = 0;
    end else if (link.scl && !scl_p && bits < 8) begin
      sh = {sh[6:0], link.sda};
      bits++;
      if (bits == 8) chk(sh[7:1], twowire_pkg::BASE_ADDR7 + sel_m, "address");
    end
    scl_p = link.scl;
    sda_p = link.sda;
  end
  initial begin
    #3_600_000;
    errors++;
    test_done();
  end
  initial begin
    {cmd_valid, cmd_read, cmd_sub, cmd_len, wdata_valid, wdata, hold, sel_m, sel_s} = '0;
    for (int k = 0; k < 256; k++) mem[k] = $random(seed);
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    for (int s = 0; s < 8; s++) begin
      sel_m <= s[2:0];
      sel_s <= s[2:0];
      xfer(1'b0, s[3:0], s, 1'b0);
      xfer(1'b1, s[3:0], s == 0 ? 1 : s, 1'b0);
    end
    sel_m <= 3'h5;
    xfer(1'b0, 4'h2, 0, 1'b1);
    xfer(1'b1, 4'h1, 0, 1'b1);
    sel_m <= 3'h7;
    drain();
    hold <= 1'b1;
    xfer(1'b0, 4'hf, 15, 1'b0);
    xfer(1'b0, 4'h3, 1, 1'b1);
    hold <= 1'b0;
    drain();
    chk(wq.size() + rq.size() + nq.size(), 16'h0000, "left over");
    test_done();
  end
endmodule
